/* File: design/afi_cmd.sv */
// Contract
// - flush-ext EAh commits every dirty cached sector to media except one that failed in an earlier flush
// - busy_flag stays set until flush finishes or fails
// - successful flush completes with ready_flag and seek_complete_flag set
// - flush-ext with flush_ext_en_pin held low aborts the command
// - write error aborts flush and reports failing 48-bit sector address
// - next flush resumes at sector after the failed one
// - format 50h fills selected range with the fill pattern
// - format accepts one sector of write data and discards it
// - LBA format count comes from sector count, zero meaning 256
// - format start: head/LBA27:24, cyl high LBA23:16, cyl low LBA15:8
// - identify ECh returns parameter block via read data-in protocol
// - reserved identify bits and words read as zero
// - word 0 is 045Ah fixed, 848Ah when configured removable
// - words 7-8 hold total sectors, high word first
// - words 10-19 hold 20-byte right-justified ASCII serial
// - firmware 23-26 and model 27-46 ASCII, first char high byte
// - word 47 reports 8001h
// - word 49 advertises DMA, LBA, flow control; word 51 PIO mode 2
// - word 53 returns 0007h
// - words 57-58 capacity low word first; 60-61 total LBA sectors
// - word 59 shows multiple setting; word 62 reads zero

////////////////////////////////////////////////////////////////////////////////
module afi_fifo
  import afi_pkg::*;
#(
  parameter int W = WORD_W,
  parameter int D = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != FULL_CNT);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rp_ff];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_wp = push ? AW'(wp_ff + 1'b1) : wp_ff;
    nxt_rp = pop ? AW'(rp_ff + 1'b1) : rp_ff;
    nxt_cnt = CW'(cnt_ff + CW'(push) - CW'(pop));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module afi_cmd
  import afi_pkg::*;
#(
  parameter logic [31:0] TOTAL_SECTORS = 32'h0010_0000,
  parameter logic [15:0] CYLINDERS = 16'h0400,
  parameter logic [15:0] HEADS = 16'h0010,
  parameter logic [15:0] SECTORS_PER_TRACK = 16'h003F,
  parameter logic [159:0] SERIAL_STR = "          0000000001",
  parameter logic [63:0] FW_STR = "REV00001",
  parameter logic [319:0] MODEL_STR = "                           SOLIDSTATE1"
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire afi_tf_s cmd_tf,
  input wire logic flush_ext_en_pin,
  input wire logic removable_cfg_pin,
  input wire logic [7:0] mult_setting,
  output logic busy_flag,
  output logic ready_flag,
  output logic seek_complete_flag,
  output logic error_flag,
  output logic abort_flag,
  output logic cmd_done,
  output logic [47:0] err_lba,
  input wire logic cache_dirty,
  input wire logic [47:0] cache_first_lba,
  input wire logic [47:0] cache_last_lba,
  output logic cache_clean,
  output logic media_req_valid,
  output afi_media_s media_req,
  input wire logic media_ack,
  input wire logic media_err,
  input wire logic wr_valid,
  input wire logic [15:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [15:0] rd_data,
  input wire logic rd_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] flush_en_sync_ff, removable_sync_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flush_en_sync_ff <= '0;
      removable_sync_ff <= '0;
    end else begin
      flush_en_sync_ff <= {flush_en_sync_ff[0], flush_ext_en_pin};
      removable_sync_ff <= {removable_sync_ff[0], removable_cfg_pin};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // identify block: words 63 and up are outside this block and read zero
  function automatic logic [15:0] id_word(input logic [7:0] idx, input logic removable, input logic [7:0] mult);
    logic [15:0] w;
    w = 16'h0000;
    if (idx >= ID_SERIAL_FIRST && idx <= ID_SERIAL_LAST) begin
      w = SERIAL_STR[159 - 16 * int'(idx - ID_SERIAL_FIRST) -: 16];
    end else if (idx >= ID_FW_FIRST && idx <= ID_FW_LAST) begin
      w = FW_STR[63 - 16 * int'(idx - ID_FW_FIRST) -: 16];
    end else if (idx >= ID_MODEL_FIRST && idx <= ID_MODEL_LAST) begin
      w = MODEL_STR[319 - 16 * int'(idx - ID_MODEL_FIRST) -: 16];
    end else begin
      unique case (idx)
        8'h00: w = removable ? ID_W0_REMOV : ID_W0_FIXED;
        8'h01: w = CYLINDERS;
        8'h03: w = HEADS;
        8'h05: w = ID_W5;
        8'h06: w = SECTORS_PER_TRACK;
        8'h07: w = TOTAL_SECTORS[31:16];
        8'h08: w = TOTAL_SECTORS[15:0];
        8'h14: w = ID_W20;
        8'h15: w = ID_W21;
        8'h16: w = ID_W22;
        8'h2F: w = ID_W47;
        8'h31: w = ID_W49;
        8'h32: w = ID_W50;
        8'h33: w = ID_W51;
        8'h35: w = ID_W53;
        8'h36: w = CYLINDERS;
        8'h37: w = HEADS;
        8'h38: w = SECTORS_PER_TRACK;
        8'h39: w = TOTAL_SECTORS[15:0];
        8'h3A: w = TOTAL_SECTORS[31:16];
        8'h3B: w = {ID_W59_HI, mult};
        8'h3C: w = TOTAL_SECTORS[15:0];
        8'h3D: w = TOTAL_SECTORS[31:16];
        default: w = 16'h0000;
      endcase
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command engine
  afi_state_e state_ff, nxt_state;
  logic [47:0] lba_ff, nxt_lba, last_ff, nxt_last, resume_ff, nxt_resume, err_lba_ff, nxt_err_lba;
  logic resume_valid_ff, nxt_resume_valid;
  logic [8:0] left_ff, nxt_left;
  logic [7:0] word_ff, nxt_word;
  logic busy_ff, nxt_busy, rdy_ff, nxt_rdy, dsc_ff, nxt_dsc, err_ff, nxt_err, abrt_ff, nxt_abrt;
  logic done_ff, nxt_done, clean_ff, nxt_clean, mreq_v_ff, nxt_mreq_v, wr_ready_ff, nxt_wr_ready;
  afi_media_s mreq_ff, nxt_mreq;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, drained;
  logic [15:0] fifo_in_data, fifo_out_data;
  logic [47:0] fmt_start;
  logic [8:0] fmt_count;
  logic [47:0] flush_start;
  logic rd_valid_ff;

  always_comb begin
    fmt_start = {20'h00000, cmd_tf.dev_head[3:0], cmd_tf.cyl_high, cmd_tf.cyl_low, 8'h00};
    if (cmd_tf.dev_head[DH_LBA_BIT]) begin
      fmt_count = (cmd_tf.sector_count == 8'h00) ? FMT_ZERO_COUNT : {1'b0, cmd_tf.sector_count};
    end else begin
      fmt_count = SECTORS_PER_TRACK[8:0];
    end
    flush_start = resume_valid_ff ? 48'(resume_ff + 48'h1) : cache_first_lba;
    fifo_in_valid = (state_ff == ST_ID_SEND);
    fifo_in_data = id_word(word_ff, removable_sync_ff[1], mult_setting);
    drained = !fifo_out_valid && !rd_valid_ff;

    nxt_state = state_ff;
    nxt_lba = lba_ff;
    nxt_last = last_ff;
    nxt_resume = resume_ff;
    nxt_resume_valid = resume_valid_ff;
    nxt_err_lba = err_lba_ff;
    nxt_left = left_ff;
    nxt_word = word_ff;
    nxt_busy = busy_ff;
    nxt_rdy = rdy_ff;
    nxt_dsc = dsc_ff;
    nxt_err = err_ff;
    nxt_abrt = abrt_ff;
    nxt_done = 1'b0;
    nxt_clean = 1'b0;
    nxt_mreq_v = 1'b0;
    nxt_mreq = mreq_ff;
    nxt_wr_ready = wr_ready_ff;

    unique case (state_ff)
      ST_IDLE: begin
        // commands arriving while busy are ignored, the host must wait
        if (cmd_valid) begin
          nxt_busy = 1'b1;
          nxt_rdy = 1'b0;
          nxt_dsc = 1'b0;
          nxt_err = 1'b0;
          nxt_abrt = 1'b0;
          unique case (cmd_tf.opcode)
            OP_FLUSH_EXT: begin
              if (!flush_en_sync_ff[1]) begin
                nxt_busy = 1'b0;
                nxt_rdy = 1'b1;
                nxt_err = 1'b1;
                nxt_abrt = 1'b1;
                nxt_done = 1'b1;
              end else if (!cache_dirty || (flush_start > cache_last_lba)) begin
                nxt_busy = 1'b0;
                nxt_rdy = 1'b1;
                nxt_dsc = 1'b1;
                nxt_done = 1'b1;
                nxt_resume_valid = 1'b0;
              end else begin
                nxt_lba = flush_start;
                nxt_last = cache_last_lba;
                nxt_state = ST_FL_ISSUE;
              end
            end
            OP_FORMAT: begin
              nxt_lba = fmt_start;
              nxt_left = fmt_count;
              nxt_word = 8'h00;
              nxt_wr_ready = 1'b1;
              nxt_state = ST_FMT_DATA;
            end
            OP_IDENTIFY: begin
              nxt_word = 8'h00;
              nxt_state = ST_ID_SEND;
            end
            default: begin
              nxt_busy = 1'b0;
              nxt_rdy = 1'b1;
              nxt_err = 1'b1;
              nxt_abrt = 1'b1;
              nxt_done = 1'b1;
            end
          endcase
        end
      end
      ST_FL_ISSUE, ST_FMT_ISSUE: begin
        nxt_mreq_v = 1'b1;
        nxt_mreq.lba = lba_ff;
        nxt_mreq.fill = (state_ff == ST_FMT_ISSUE);
        nxt_state = (state_ff == ST_FL_ISSUE) ? ST_FL_WAIT : ST_FMT_WAIT;
      end
      ST_FL_WAIT, ST_FMT_WAIT: begin
        if (media_ack) begin
          if (media_err) begin
            nxt_busy = 1'b0;
            nxt_rdy = 1'b1;
            nxt_err = 1'b1;
            nxt_abrt = 1'b1;
            nxt_err_lba = lba_ff;
            nxt_done = 1'b1;
            nxt_state = ST_IDLE;
            if (state_ff == ST_FL_WAIT) begin
              nxt_resume = lba_ff;
              nxt_resume_valid = 1'b1;
            end
          end else if ((state_ff == ST_FL_WAIT) ? (lba_ff == last_ff) : (left_ff == 9'h001)) begin
            nxt_busy = 1'b0;
            nxt_rdy = 1'b1;
            nxt_dsc = 1'b1;
            nxt_done = 1'b1;
            nxt_state = ST_IDLE;
            if (state_ff == ST_FL_WAIT) begin
              nxt_resume_valid = 1'b0;
              nxt_clean = 1'b1;
            end
          end else begin
            nxt_lba = 48'(lba_ff + 48'h1);
            nxt_left = 9'(left_ff - 9'h001);
            nxt_state = (state_ff == ST_FL_WAIT) ? ST_FL_ISSUE : ST_FMT_ISSUE;
          end
        end
      end
      ST_FMT_DATA: begin
        // the buffer contents are dropped, only the word count matters
        if (wr_valid && wr_ready_ff) begin
          nxt_word = 8'(word_ff + 8'h01);
          if (word_ff == LAST_WORD) begin
            nxt_wr_ready = 1'b0;
            nxt_state = ST_FMT_ISSUE;
          end
        end
      end
      ST_ID_SEND: begin
        if (fifo_in_ready) begin
          nxt_word = 8'(word_ff + 8'h01);
          if (word_ff == LAST_WORD) begin
            nxt_state = ST_ID_DRAIN;
          end
        end
      end
      ST_ID_DRAIN: begin
        // busy holds until the host has taken the last word
        if (drained) begin
          nxt_busy = 1'b0;
          nxt_rdy = 1'b1;
          nxt_dsc = 1'b1;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      lba_ff <= '0;
      last_ff <= '0;
      resume_ff <= '0;
      resume_valid_ff <= 1'b0;
      err_lba_ff <= '0;
      left_ff <= '0;
      word_ff <= '0;
      busy_ff <= 1'b0;
      rdy_ff <= 1'b1;
      dsc_ff <= 1'b1;
      err_ff <= 1'b0;
      abrt_ff <= 1'b0;
      done_ff <= 1'b0;
      clean_ff <= 1'b0;
      mreq_v_ff <= 1'b0;
      mreq_ff <= '0;
      wr_ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lba_ff <= nxt_lba;
      last_ff <= nxt_last;
      resume_ff <= nxt_resume;
      resume_valid_ff <= nxt_resume_valid;
      err_lba_ff <= nxt_err_lba;
      left_ff <= nxt_left;
      word_ff <= nxt_word;
      busy_ff <= nxt_busy;
      rdy_ff <= nxt_rdy;
      dsc_ff <= nxt_dsc;
      err_ff <= nxt_err;
      abrt_ff <= nxt_abrt;
      done_ff <= nxt_done;
      clean_ff <= nxt_clean;
      mreq_v_ff <= nxt_mreq_v;
      mreq_ff <= nxt_mreq;
      wr_ready_ff <= nxt_wr_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data-in buffer and output register
  afi_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  logic nxt_rd_valid;
  logic [15:0] rd_data_ff, nxt_rd_data;

  always_comb begin
    // a register stage keeps rd_data off the fifo read mux
    fifo_out_ready = !rd_valid_ff || rd_ready;
    nxt_rd_valid = rd_valid_ff;
    nxt_rd_data = rd_data_ff;
    if (fifo_out_ready) begin
      nxt_rd_valid = fifo_out_valid;
      nxt_rd_data = fifo_out_valid ? fifo_out_data : rd_data_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= '0;
    end else begin
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign busy_flag = busy_ff;
  assign ready_flag = rdy_ff;
  assign seek_complete_flag = dsc_ff;
  assign error_flag = err_ff;
  assign abort_flag = abrt_ff;
  assign cmd_done = done_ff;
  assign err_lba = err_lba_ff;
  assign cache_clean = clean_ff;
  assign media_req_valid = mreq_v_ff;
  assign media_req = mreq_ff;
  assign wr_ready = wr_ready_ff;
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;

endmodule

/* File: inc/afi_pkg.sv */
package afi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command opcodes and task-file fields
  localparam logic [7:0] OP_FLUSH_EXT = 8'hEA;
  localparam logic [7:0] OP_FORMAT = 8'h50;
  localparam logic [7:0] OP_IDENTIFY = 8'hEC;
  localparam int DH_LBA_BIT = 6;
  localparam logic [8:0] FMT_ZERO_COUNT = 9'h100;

  ////////////////////////////////////////////////////////////////////////////
  // data path
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] LAST_WORD = 8'hFF;
  localparam logic [15:0] FILL_PATTERN = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // identify block words
  localparam logic [15:0] ID_W0_FIXED = 16'h045A;
  localparam logic [15:0] ID_W0_REMOV = 16'h848A;
  localparam logic [15:0] ID_W5 = 16'h0200;
  localparam logic [15:0] ID_W20 = 16'h0002;
  localparam logic [15:0] ID_W21 = 16'h0001;
  localparam logic [15:0] ID_W22 = 16'h0004;
  localparam logic [15:0] ID_W47 = 16'h8001;
  localparam logic [15:0] ID_W49 = 16'h0F00;
  localparam logic [15:0] ID_W50 = 16'h4001;
  localparam logic [15:0] ID_W51 = 16'h0200;
  localparam logic [15:0] ID_W53 = 16'h0007;
  localparam logic [7:0] ID_W59_HI = 8'h01;
  localparam logic [7:0] ID_SERIAL_FIRST = 8'h0A;
  localparam logic [7:0] ID_SERIAL_LAST = 8'h13;
  localparam logic [7:0] ID_FW_FIRST = 8'h17;
  localparam logic [7:0] ID_FW_LAST = 8'h1A;
  localparam logic [7:0] ID_MODEL_FIRST = 8'h1B;
  localparam logic [7:0] ID_MODEL_LAST = 8'h2E;

  ////////////////////////////////////////////////////////////////////////////
  // carriers and states
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] sector_count;
    logic [7:0] sector_num;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] dev_head;
  } afi_tf_s;

  typedef struct packed {
    logic [47:0] lba;
    logic fill;
  } afi_media_s;

  typedef enum {
    ST_IDLE, ST_FL_ISSUE, ST_FL_WAIT, ST_FMT_DATA, ST_FMT_ISSUE, ST_FMT_WAIT, ST_ID_SEND, ST_ID_DRAIN
  } afi_state_e;

endpackage

/* File: verification/afi_cmd_properties.sv */
module afi_cmd_props
  import afi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire afi_tf_s cmd_tf,
  input wire logic flush_ext_en_pin,
  input wire logic busy_flag,
  input wire logic ready_flag,
  input wire logic seek_complete_flag,
  input wire logic error_flag,
  input wire logic abort_flag,
  input wire logic cmd_done,
  input wire logic [47:0] err_lba,
  input wire logic cache_clean,
  input wire logic media_req_valid,
  input wire afi_media_s media_req,
  input wire logic media_ack,
  input wire logic media_err,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic rd_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] op_ff;
  logic [7:0] nxt_op;
  logic take;
  assign take = cmd_valid && !busy_flag;
  // remembers which command owns the media requests
  always_comb begin
    nxt_op = op_ff;
    if (take) nxt_op = cmd_tf.opcode;
  end
  always_ff @(posedge core_clk) begin
    if (rst) op_ff <= 8'h00;
    else op_ff <= nxt_op;
  end
  ////////////////////////////////////////////////////////////
  a_id_latency: assert property (take && cmd_tf.opcode == OP_IDENTIFY |=> busy_flag ##2 rd_valid)
    else $error("identify data not started in time");
  // pin goes through two flops, so demand three low samples
  a_no_flush_abort: assert property (take && cmd_tf.opcode == OP_FLUSH_EXT && !flush_ext_en_pin
    && !$past(flush_ext_en_pin) && !$past(flush_ext_en_pin, 2) |=> cmd_done && abort_flag && error_flag)
    else $error("unsupported flush not aborted");
  a_busy_drop_done: assert property ($fell(busy_flag) |-> cmd_done)
    else $error("busy released without completion");
  a_done_idle: assert property (cmd_done |-> !busy_flag && ready_flag)
    else $error("completion while busy");
  a_clean_status: assert property (cache_clean |-> cmd_done && seek_complete_flag && !error_flag)
    else $error("flush completion status wrong");
  a_err_report: assert property (busy_flag && media_ack && media_err
    |=> cmd_done && abort_flag && err_lba == media_req.lba)
    else $error("media error not reported");
  a_fmt_fill: assert property (media_req_valid && op_ff == OP_FORMAT |-> media_req.fill)
    else $error("format request without fill");
  a_flush_commit: assert property (media_req_valid && op_ff == OP_FLUSH_EXT |-> !media_req.fill)
    else $error("flush request with fill");
  a_rd_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
    else $error("read word dropped during stall");
  a_wr_owner: assert property (wr_ready |-> busy_flag && op_ff == OP_FORMAT)
    else $error("write data taken outside format");
  c_clean: cover property (cache_clean);
  c_media_err: cover property (media_ack && media_err && busy_flag);
  c_rd_stall: cover property (rd_valid && !rd_ready ##1 rd_valid);
endmodule

bind afi_cmd afi_cmd_props u_props (.core_clk, .rst, .cmd_valid, .cmd_tf, .flush_ext_en_pin, .busy_flag,
  .ready_flag, .seek_complete_flag, .error_flag, .abort_flag, .cmd_done, .err_lba, .cache_clean,
  .media_req_valid, .media_req, .media_ack, .media_err, .wr_ready, .rd_valid, .rd_data, .rd_ready);

/* File: verification/afi_media_model.sv */
module afi_media_model
  import afi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic media_req_valid,
  input wire afi_media_s media_req,
  output logic media_ack,
  output logic media_err,
  input wire logic slow,
  input wire logic fail_en,
  input wire logic [47:0] fail_lba,
  output logic [15:0] req_cnt,
  output logic [47:0] first_lba,
  output logic [47:0] last_lba,
  output logic all_fill,
  output logic any_fill
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend;
  int wait_cnt;
  // error line toggles outside answers: only meaningful with ack
  always @(posedge core_clk) begin
    media_ack <= 1'b0;
    media_err <= ~media_err;
    if (rst || clr) begin
      pend <= 1'b0;
      media_err <= 1'b0;
      req_cnt <= 16'h0000;
      all_fill <= 1'b1;
      any_fill <= 1'b0;
    end else if (media_req_valid) begin
      pend <= 1'b1;
      wait_cnt <= slow ? 4 : 0;
      if (req_cnt == 16'h0000) first_lba <= media_req.lba;
      last_lba <= media_req.lba;
      all_fill <= all_fill & media_req.fill;
      any_fill <= any_fill | media_req.fill;
      req_cnt <= req_cnt + 16'h0001;
    end else if (pend) begin
      if (wait_cnt == 0) begin
        pend <= 1'b0;
        media_ack <= 1'b1;
        media_err <= fail_en && last_lba == fail_lba;
      end else begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule

/* File: verification/tb_ata_flush_format_identify_cmd.sv */
module tb_ata_flush_format_identify_cmd
  import afi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] TOT = 32'h0010_0000;
  localparam logic [15:0] CYL = 16'h0400;
  localparam logic [15:0] HDS = 16'h0010;
  localparam logic [15:0] SPT = 16'h0040;
  localparam logic [159:0] SER = "ABCDEFGHIJ0123456789";
  localparam logic [63:0] FWS = "FW000123";
  localparam logic [319:0] MDL = "MODEL-TEST-UNIT-0001MODEL-TEST-UNIT-0002";
  logic core_clk, rst, cmd_valid, flush_ext_en_pin, removable_cfg_pin, cache_dirty, media_ack, media_err;
  logic busy_flag, ready_flag, seek_complete_flag, error_flag, abort_flag, cmd_done, cache_clean;
  logic media_req_valid, wr_valid, wr_ready, rd_valid, rd_ready, slow, fail_en, clr, all_fill, any_fill;
  afi_tf_s cmd_tf;
  afi_media_s media_req;
  logic [7:0] mult_setting;
  logic [47:0] err_lba, cache_first_lba, cache_last_lba, fail_lba, first_lba, last_lba;
  logic [15:0] wr_data, rd_data, req_cnt;
  int mismatches, total_checks;

  afi_cmd #(.TOTAL_SECTORS(TOT), .CYLINDERS(CYL), .HEADS(HDS), .SECTORS_PER_TRACK(SPT), .SERIAL_STR(SER),
    .FW_STR(FWS), .MODEL_STR(MDL)) dut (.core_clk, .rst, .cmd_valid, .cmd_tf, .flush_ext_en_pin,
    .removable_cfg_pin, .mult_setting, .busy_flag, .ready_flag, .seek_complete_flag, .error_flag, .abort_flag,
    .cmd_done, .err_lba, .cache_dirty, .cache_first_lba, .cache_last_lba, .cache_clean, .media_req_valid,
    .media_req, .media_ack, .media_err, .wr_valid, .wr_data, .wr_ready, .rd_valid, .rd_data, .rd_ready);
  afi_media_model media (.core_clk, .rst, .clr, .media_req_valid, .media_req, .media_ack, .media_err, .slow,
    .fail_en, .fail_lba, .req_cnt, .first_lba, .last_lba, .all_fill, .any_fill);

  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  // model counters clear on the command's edge
  task automatic issue(input logic [7:0] op, input logic [7:0] sc, input logic [7:0] dh);
    @(negedge core_clk);
    cmd_tf = '{op, sc, 8'hA5, 8'h34, 8'h12, dh};
    cmd_valid = 1'b1;
    clr = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    clr = 1'b0;
  endtask
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (cmd_done !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        mismatches++;
        $display("unexpected at %0t: command never finished", $time);
        tally_and_finish();
      end
    end
  endtask
  function automatic logic [15:0] exp_word(input int w, input logic rem);
    case (w)
      0: exp_word = rem ? 16'h848A : 16'h045A;
      1, 54: exp_word = CYL;
      3, 55: exp_word = HDS;
      5: exp_word = 16'h0200;
      6, 56: exp_word = SPT;
      7, 58, 61: exp_word = TOT[31:16];
      8, 57, 60: exp_word = TOT[15:0];
      20: exp_word = 16'h0002;
      21: exp_word = 16'h0001;
      22: exp_word = 16'h0004;
      47: exp_word = 16'h8001;
      49: exp_word = 16'h0F00;
      50: exp_word = 16'h4001;
      51: exp_word = 16'h0200;
      53: exp_word = 16'h0007;
      59: exp_word = {8'h01, mult_setting};
      default: exp_word = 16'h0000;
    endcase
    if (w >= 10 && w <= 19) exp_word = SER[159 - 16 * (w - 10) -: 16];
    if (w >= 23 && w <= 26) exp_word = FWS[63 - 16 * (w - 23) -: 16];
    if (w >= 27 && w <= 46) exp_word = MDL[319 - 16 * (w - 27) -: 16];
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic t_flush(input logic [47:0] lo, input logic [47:0] hi, input logic [47:0] start, input logic bad);
    logic [47:0] stop;
    stop = bad ? fail_lba : hi;
    cache_first_lba = lo;
    cache_last_lba = hi;
    cache_dirty = 1'b1;
    fail_en = bad;
    issue(OP_FLUSH_EXT, 8'h00, 8'hE0);
    chk(busy_flag, 1'b1, "busy at start");
    wait_done(400);
    chk(first_lba, start, "first flushed sector");
    chk(last_lba, stop, "last flushed sector");
    chk(req_cnt, stop - start + 48'h1, "flushed sector count");
    chk(any_fill, 1'b0, "flush wrote fill");
    chk({abort_flag, error_flag}, {bad, bad}, "abort status");
    chk({cache_clean, seek_complete_flag | bad}, {!bad, 1'b1}, "flush status");
    if (bad) chk(err_lba, fail_lba, "failing sector");
    @(negedge core_clk);
  endtask
  task automatic t_no_flush();
    flush_ext_en_pin = 1'b0;
    repeat (3) @(negedge core_clk);
    issue(OP_FLUSH_EXT, 8'h00, 8'hE0);
    chk({cmd_done, abort_flag, error_flag, busy_flag}, 4'b1110, "unsupported flush");
    issue(8'h00, 8'h00, 8'h00);
    chk({cmd_done, abort_flag, error_flag, busy_flag}, 4'b1110, "bad opcode");
    flush_ext_en_pin = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  // host should avoid format; used here only to prove it
  task automatic t_format(input logic [7:0] sc, input logic [7:0] dh, input int cnt);
    int n;
    int k;
    n = 0;
    k = 0;
    issue(OP_FORMAT, sc, dh);
    wr_valid = 1'b1;
    while (n < 256 && k < 600) begin
      wr_data = 16'(n) ^ 16'hA5C3;
      if (wr_ready === 1'b1) n++;
      k++;
      @(negedge core_clk);
    end
    chk(n, 256, "format data words");
    if (n != 256) tally_and_finish();
    chk(wr_ready, 1'b0, "extra word refused");
    @(negedge core_clk);
    wr_valid = 1'b0;
    wait_done(2000);
    chk(req_cnt, cnt, "format sector count");
    chk(first_lba, {20'h00000, dh[3:0], 24'h123400}, "format start");
    chk(last_lba, first_lba + 48'(cnt - 1), "format end");
    chk({all_fill, cmd_done, abort_flag}, 3'b110, "format status");
    @(negedge core_clk);
  endtask
  task automatic t_identify(input logic rem);
    int n;
    int k;
    removable_cfg_pin = rem;
    rd_ready = 1'b0;
    repeat (3) @(negedge core_clk);
    issue(OP_IDENTIFY, 8'h00, 8'h00);
    issue(OP_FORMAT, 8'h01, 8'h40);
    chk(wr_ready, 1'b0, "command taken while busy");
    repeat (16) @(negedge core_clk);
    n = 0;
    k = 0;
    while (n < 256 && k < 2000) begin
      rd_ready = (k % 7) != 3;
      if (rd_valid === 1'b1 && rd_ready) begin
        chk(rd_data, exp_word(n, rem), "identify word");
        n++;
      end
      k++;
      @(negedge core_clk);
    end
    chk(n, 256, "identify word count");
    if (n != 256) tally_and_finish();
    wait_done(20);
    chk({ready_flag, seek_complete_flag, busy_flag}, 3'b110, "identify done");
    @(negedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_tf = '0;
    flush_ext_en_pin = 1'b1;
    removable_cfg_pin = 1'b0;
    mult_setting = 8'h10;
    cache_dirty = 1'b0;
    cache_first_lba = '0;
    cache_last_lba = '0;
    wr_valid = 1'b0;
    wr_data = '0;
    rd_ready = 1'b1;
    slow = 1'b1;
    fail_en = 1'b0;
    fail_lba = 48'h0000_0000_0016;
    clr = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({busy_flag, ready_flag, seek_complete_flag, error_flag}, 4'b0110, "reset status");
    t_flush(48'h10, 48'h13, 48'h10, 1'b0);
    slow = 1'b0;
    t_flush(48'h14, 48'h19, 48'h14, 1'b1);
    t_flush(48'h14, 48'h19, 48'h17, 1'b0);
    t_no_flush();
    t_format(8'h03, 8'h45, 3);
    t_format(8'h00, 8'h45, 256);
    t_format(8'h07, 8'h05, int'(SPT));
    t_identify(1'b0);
    t_identify(1'b1);
    tally_and_finish();
  end
endmodule
